// >>> design/lowpower_pkg.sv
package lowpower_pkg;

   // ----------------------------------------------------------------
   // Management map: device groups and register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] MMD_PCS = 5'h03;
   localparam logic [4:0] MMD_AUTONEG = 5'h07;
   localparam logic [15:0] PCS_LOWPOWER_CONTROL_OFFSET = 16'h0000;
   localparam logic [15:0] PCS_LOWPOWER_STATUS_OFFSET = 16'h0001;
   localparam logic [15:0] LOWPOWER_ADVERTISE_OFFSET = 16'h003c;
   localparam logic [15:0] PARTNER_LOWPOWER_ADVERTISE_OFFSET = 16'h003d;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ADV_100_BIT = 1;
   localparam int ADV_1000_BIT = 2;
   localparam int CTRL_CLK_STOP_BIT = 10;
   localparam int STAT_RX_LPI_BIT = 8;
   localparam int STAT_TX_LPI_BIT = 9;
   localparam int STAT_RX_SEEN_BIT = 10;
   localparam int STAT_TX_SEEN_BIT = 11;
   localparam int STAT_TX_STOP_OK_BIT = 12;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CONTROL_RESET = 16'h0400;
   localparam logic [15:0] ADVERTISE_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Low-power idle codes and cycle counts
   // ----------------------------------------------------------------
   localparam logic [7:0] LPI_BYTE = 8'h01;
   localparam logic [3:0] LPI_NIBBLE = 4'h1;
   localparam logic [3:0] LPI_HOLD_CYCLES = 4'ha;
   localparam logic [3:0] RX_HALF_1000_LAST = 4'h3;
   localparam logic [3:0] RX_HALF_100_LAST = 4'h9;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic {TX_NORMAL, TX_LPI} tx_state_t;
   typedef enum logic [1:0] {RX_NORMAL, RX_LPI, RX_STOPPED} rx_state_t;

endpackage : lowpower_pkg

// >>> design/lowpower_ctrl_if.sv
`timescale 1ns/1ps
interface lowpower_ctrl_if;
   logic tx_lpi;
   logic rx_lpi;
   logic tx_stop_ok;
   logic tx_lpi_enter;
   logic rx_lpi_enter;
   logic clk_stop_en;
   logic eee_1000;
   logic eee_100;

   modport core (
      output tx_lpi, rx_lpi, tx_stop_ok, tx_lpi_enter, rx_lpi_enter,
      input clk_stop_en, eee_1000, eee_100
   );
   modport regs (
      input tx_lpi, rx_lpi, tx_stop_ok, tx_lpi_enter, rx_lpi_enter,
      output clk_stop_en, eee_1000, eee_100
   );
endinterface : lowpower_ctrl_if

// >>> design/lowpower_regs.sv
`timescale 1ns/1ps
module lowpower_regs (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // Management access
   input wire logic i_mgmt_wr,
   input wire logic i_mgmt_rd,
   input wire logic [4:0] i_mgmt_mmd,
   input wire logic [15:0] i_mgmt_reg,
   input wire logic [15:0] i_mgmt_wdata,
   output logic [15:0] o_mgmt_rdata,
   // Partner abilities
   input wire logic [15:0] i_partner_adv,
   // Core side
   lowpower_ctrl_if.regs ctrl
);
   logic [15:0] control_q, control_d;
   logic [15:0] adv_q, adv_d;
   logic rx_seen_q, rx_seen_d;
   logic tx_seen_q, tx_seen_d;
   logic [15:0] rdata_q, rdata_d;
   logic sel_ctrl, sel_stat, sel_adv, sel_partner;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign sel_ctrl = (i_mgmt_mmd == lowpower_pkg::MMD_PCS) &&
                     (i_mgmt_reg == lowpower_pkg::PCS_LOWPOWER_CONTROL_OFFSET);
   assign sel_stat = (i_mgmt_mmd == lowpower_pkg::MMD_PCS) &&
                     (i_mgmt_reg == lowpower_pkg::PCS_LOWPOWER_STATUS_OFFSET);
   assign sel_adv = (i_mgmt_mmd == lowpower_pkg::MMD_AUTONEG) &&
                    (i_mgmt_reg == lowpower_pkg::LOWPOWER_ADVERTISE_OFFSET);
   assign sel_partner = (i_mgmt_mmd == lowpower_pkg::MMD_AUTONEG) &&
                        (i_mgmt_reg == lowpower_pkg::PARTNER_LOWPOWER_ADVERTISE_OFFSET);

   // Next values of the register file
   always_comb begin
      control_d = control_q;
      adv_d = adv_q;
      rdata_d = rdata_q;
      rx_seen_d = rx_seen_q;
      tx_seen_d = tx_seen_q;
      if (i_mgmt_wr && sel_ctrl) begin
         control_d = i_mgmt_wdata;
      end
      if (i_mgmt_wr && sel_adv) begin
         adv_d = i_mgmt_wdata;
      end
      if (i_mgmt_rd) begin
         rdata_d = 16'h0000;
         if (sel_ctrl) begin
            rdata_d = control_q;
         end else if (sel_adv) begin
            rdata_d = adv_q;
         end else if (sel_partner) begin
            rdata_d = i_partner_adv;
         end else if (sel_stat) begin
            rdata_d[lowpower_pkg::STAT_RX_LPI_BIT] = ctrl.rx_lpi;
            rdata_d[lowpower_pkg::STAT_TX_LPI_BIT] = ctrl.tx_lpi;
            rdata_d[lowpower_pkg::STAT_RX_SEEN_BIT] = rx_seen_q;
            rdata_d[lowpower_pkg::STAT_TX_SEEN_BIT] = tx_seen_q;
            rdata_d[lowpower_pkg::STAT_TX_STOP_OK_BIT] = ctrl.tx_stop_ok;
            rx_seen_d = 1'b0;
            tx_seen_d = 1'b0;
         end
      end
      // Entry events win over a clearing read
      if (ctrl.rx_lpi_enter) begin
         rx_seen_d = 1'b1;
      end
      if (ctrl.tx_lpi_enter) begin
         tx_seen_d = 1'b1;
      end
   end

   // Register stage
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         control_q <= lowpower_pkg::CONTROL_RESET;
         adv_q <= lowpower_pkg::ADVERTISE_RESET;
         rdata_q <= 16'h0000;
         rx_seen_q <= 1'b0;
         tx_seen_q <= 1'b0;
      end else begin
         control_q <= control_d;
         adv_q <= adv_d;
         rdata_q <= rdata_d;
         rx_seen_q <= rx_seen_d;
         tx_seen_q <= tx_seen_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs toward management and the core
   // ----------------------------------------------------------------
   assign o_mgmt_rdata = rdata_q;
   assign ctrl.clk_stop_en = control_q[lowpower_pkg::CTRL_CLK_STOP_BIT];
   // Both ends must advertise the speed before LPI is honoured
   assign ctrl.eee_1000 = adv_q[lowpower_pkg::ADV_1000_BIT] &
                          i_partner_adv[lowpower_pkg::ADV_1000_BIT];
   assign ctrl.eee_100 = adv_q[lowpower_pkg::ADV_100_BIT] &
                         i_partner_adv[lowpower_pkg::ADV_100_BIT];

endmodule : lowpower_regs

// >>> design/rgmii_eee_lpi_signaling.sv
`timescale 1ns/1ps
// Functional notes
// - 1000 Mbps: TX_CTL rise is enable, fall is error; nibbles low then high.
// - 100 Mbps: TX_CTL rise enable, fall error; data nibble taken on rise only.
// - Gigabit transmit LPI held while codes hold; left on any change.
// - 100 Mbps transmit LPI held while control and low nibble hold; high nibble ignored.
// - 1000 Mbps: RX_CTL rise valid, fall error; low nibble rise, high fall.
// - 100 Mbps: RX_CTL rise valid, fall error; data nibble on rise.
// - Gigabit sleep pattern drives control low/high, data 0001 then 0000.
// - Receive LPI codes kept during refresh; any other pattern resumes normal output.
// - Receive clock stops after eleven receive clock cycles in LPI: the entry cycle and ten more.
// - Transmit and receive LPI are independent states.
// - LPI is off after reset; software enables via advertisement bits.
module rgmii_eee_lpi_signaling (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // RGMII transmit pins from the MAC
   input wire logic i_gtx_clk,
   input wire logic i_tx_ctl,
   input wire logic [3:0] i_txd,
   // RGMII receive pins to the MAC
   output logic o_rx_clk,
   output logic o_rx_ctl,
   output logic [3:0] o_rxd,
   // Line-side transmit stream
   output logic o_line_tx_valid,
   output logic [7:0] o_line_tx_byte,
   output logic o_line_tx_en,
   output logic o_line_tx_er,
   output logic o_line_tx_lpi,
   // Line-side receive stream
   input wire logic i_line_rx_dv,
   input wire logic i_line_rx_er,
   input wire logic [7:0] i_line_rx_byte,
   input wire logic i_line_rx_sleep,
   output logic o_line_rx_take,
   // Link status
   input wire logic i_speed_1000,
   input wire logic [15:0] i_partner_adv,
   // Management access
   input wire logic i_mgmt_wr,
   input wire logic i_mgmt_rd,
   input wire logic [4:0] i_mgmt_mmd,
   input wire logic [15:0] i_mgmt_reg,
   input wire logic [15:0] i_mgmt_wdata,
   output logic [15:0] o_mgmt_rdata
);
   lowpower_ctrl_if ctrl ();

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   lowpower_regs regs_inst (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_mgmt_wr(i_mgmt_wr),
      .i_mgmt_rd(i_mgmt_rd),
      .i_mgmt_mmd(i_mgmt_mmd),
      .i_mgmt_reg(i_mgmt_reg),
      .i_mgmt_wdata(i_mgmt_wdata),
      .o_mgmt_rdata(o_mgmt_rdata),
      .i_partner_adv(i_partner_adv),
      .ctrl(ctrl.regs)
   );

   logic eee_on;
   assign eee_on = i_speed_1000 ? ctrl.eee_1000 : ctrl.eee_100;

   // ----------------------------------------------------------------
   // Transmit pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] tx_meta_q;
   logic [5:0] tx_sync_q;
   logic gtx_prev_q;
   logic gtx_rise, gtx_fall;
   logic sync_ctl;
   logic [3:0] sync_txd;

   // Clock, control and data pass two flops together
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tx_meta_q <= 6'h00;
         tx_sync_q <= 6'h00;
         gtx_prev_q <= 1'b0;
      end else begin
         tx_meta_q <= {i_gtx_clk, i_tx_ctl, i_txd};
         tx_sync_q <= tx_meta_q;
         gtx_prev_q <= tx_sync_q[5];
      end
   end

   assign gtx_rise = tx_sync_q[5] & ~gtx_prev_q;
   assign gtx_fall = ~tx_sync_q[5] & gtx_prev_q;
   assign sync_ctl = tx_sync_q[4];
   assign sync_txd = tx_sync_q[3:0];

   // ----------------------------------------------------------------
   // Transmit sampling and LPI detection
   // ----------------------------------------------------------------
   lowpower_pkg::tx_state_t tx_state_q, tx_state_d;
   logic tx_en_half_q, tx_en_half_d;
   logic [3:0] tx_lo_q, tx_lo_d;
   logic tx_valid_q, tx_valid_d;
   logic [7:0] tx_byte_q, tx_byte_d;
   logic tx_en_q, tx_en_d;
   logic tx_er_q, tx_er_d;
   logic [3:0] tx_cnt_q, tx_cnt_d;
   logic tx_enter;
   logic [7:0] tx_full_byte;
   logic tx_lpi_code;

   assign tx_full_byte = i_speed_1000 ? {sync_txd, tx_lo_q} : {4'h0, tx_lo_q};
   // Gigabit checks the whole byte, 100 Mbps only the low nibble
   assign tx_lpi_code = ~tx_en_half_q & sync_ctl & eee_on &
                        (i_speed_1000 ? (tx_full_byte == lowpower_pkg::LPI_BYTE)
                                      : (tx_lo_q == lowpower_pkg::LPI_NIBBLE));

   // Next transmit state
   always_comb begin
      tx_state_d = tx_state_q;
      tx_en_half_d = tx_en_half_q;
      tx_lo_d = tx_lo_q;
      tx_valid_d = 1'b0;
      tx_byte_d = tx_byte_q;
      tx_en_d = tx_en_q;
      tx_er_d = tx_er_q;
      tx_cnt_d = tx_cnt_q;
      tx_enter = 1'b0;
      if (gtx_rise) begin
         tx_en_half_d = sync_ctl;
         tx_lo_d = sync_txd;
         // Early exit on an enable or low nibble change
         if (tx_state_q == lowpower_pkg::TX_LPI &&
             (sync_ctl || sync_txd != lowpower_pkg::LPI_NIBBLE)) begin
            tx_state_d = lowpower_pkg::TX_NORMAL;
         end
      end else if (gtx_fall) begin
         tx_valid_d = 1'b1;
         tx_byte_d = tx_full_byte;
         tx_en_d = tx_en_half_q;
         tx_er_d = sync_ctl;
         case (tx_state_q)
            lowpower_pkg::TX_NORMAL: begin
               if (tx_lpi_code) begin
                  tx_state_d = lowpower_pkg::TX_LPI;
                  tx_enter = 1'b1;
                  tx_cnt_d = 4'h1;
               end
            end
            lowpower_pkg::TX_LPI: begin
               if (!tx_lpi_code) begin
                  tx_state_d = lowpower_pkg::TX_NORMAL;
               end else if (tx_cnt_q != lowpower_pkg::LPI_HOLD_CYCLES) begin
                  tx_cnt_d = tx_cnt_q + 4'h1;
               end
            end
            default: tx_state_d = lowpower_pkg::TX_NORMAL;
         endcase
      end
      if (tx_state_d == lowpower_pkg::TX_NORMAL) begin
         tx_cnt_d = 4'h0;
      end
   end

   // Transmit registers
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tx_state_q <= lowpower_pkg::TX_NORMAL;
         tx_en_half_q <= 1'b0;
         tx_lo_q <= 4'h0;
         tx_valid_q <= 1'b0;
         tx_byte_q <= 8'h00;
         tx_en_q <= 1'b0;
         tx_er_q <= 1'b0;
         tx_cnt_q <= 4'h0;
      end else begin
         tx_state_q <= tx_state_d;
         tx_en_half_q <= tx_en_half_d;
         tx_lo_q <= tx_lo_d;
         tx_valid_q <= tx_valid_d;
         tx_byte_q <= tx_byte_d;
         tx_en_q <= tx_en_d;
         tx_er_q <= tx_er_d;
         tx_cnt_q <= tx_cnt_d;
      end
   end

   assign o_line_tx_valid = tx_valid_q;
   assign o_line_tx_byte = tx_byte_q;
   assign o_line_tx_en = tx_en_q;
   assign o_line_tx_er = tx_er_q;
   assign o_line_tx_lpi = (tx_state_q == lowpower_pkg::TX_LPI);
   assign ctrl.tx_lpi = (tx_state_q == lowpower_pkg::TX_LPI);
   assign ctrl.tx_lpi_enter = tx_enter;
   // Tells software the MAC may now halt its clock
   assign ctrl.tx_stop_ok = (tx_cnt_q == lowpower_pkg::LPI_HOLD_CYCLES);

   // ----------------------------------------------------------------
   // Receive clock generation and output encoding
   // ----------------------------------------------------------------
   lowpower_pkg::rx_state_t rx_state_q, rx_state_d;
   logic [3:0] rx_div_q, rx_div_d;
   logic rx_phase_q, rx_phase_d;
   logic rx_clk_q, rx_clk_d;
   logic rx_ctl_q, rx_ctl_d;
   logic [3:0] rxd_q, rxd_d;
   logic [3:0] rx_hi_q, rx_hi_d;
   logic rx_er_q, rx_er_d;
   logic [3:0] rx_cnt_q, rx_cnt_d;
   logic rx_take_q, rx_take_d;
   logic rx_enter;
   logic rx_tick;
   logic rx_sleep;

   assign rx_tick = (rx_div_q == (i_speed_1000 ? lowpower_pkg::RX_HALF_1000_LAST
                                               : lowpower_pkg::RX_HALF_100_LAST));
   assign rx_sleep = i_line_rx_sleep & eee_on;

   // Next receive state
   always_comb begin
      rx_state_d = rx_state_q;
      rx_div_d = rx_tick ? 4'h0 : rx_div_q + 4'h1;
      rx_phase_d = rx_phase_q;
      rx_clk_d = rx_clk_q;
      rx_ctl_d = rx_ctl_q;
      rxd_d = rxd_q;
      rx_hi_d = rx_hi_q;
      rx_er_d = rx_er_q;
      rx_cnt_d = rx_cnt_q;
      rx_take_d = 1'b0;
      rx_enter = 1'b0;
      if (rx_tick && !rx_phase_q) begin
         // Rising half: take one line symbol
         rx_phase_d = 1'b1;
         rx_take_d = 1'b1;
         if (rx_sleep) begin
            if (rx_state_q == lowpower_pkg::RX_NORMAL) begin
               rx_state_d = lowpower_pkg::RX_LPI;
               rx_enter = 1'b1;
               rx_cnt_d = 4'h0;
            end
            rx_ctl_d = 1'b0;
            rxd_d = lowpower_pkg::LPI_BYTE[3:0];
            // 100 Mbps repeats the low nibble, so LPI shows 0001 in both halves
            rx_hi_d = i_speed_1000 ? lowpower_pkg::LPI_BYTE[7:4]
                                   : lowpower_pkg::LPI_BYTE[3:0];
            rx_er_d = 1'b1;
            if (rx_state_q != lowpower_pkg::RX_NORMAL &&
                rx_cnt_q != lowpower_pkg::LPI_HOLD_CYCLES) begin
               rx_cnt_d = rx_cnt_q + 4'h1;
            end
         end else begin
            rx_state_d = lowpower_pkg::RX_NORMAL;
            rx_ctl_d = i_line_rx_dv;
            rxd_d = i_line_rx_byte[3:0];
            rx_hi_d = i_speed_1000 ? i_line_rx_byte[7:4] : i_line_rx_byte[3:0];
            rx_er_d = i_line_rx_er;
            rx_cnt_d = 4'h0;
         end
         rx_clk_d = (rx_state_d != lowpower_pkg::RX_STOPPED);
      end else if (rx_tick) begin
         // Falling half: error on control, high nibble at 1000 Mbps or low nibble at 100 Mbps on data
         rx_phase_d = 1'b0;
         rx_clk_d = 1'b0;
         rx_ctl_d = rx_er_q;
         rxd_d = rx_hi_q;
         case (rx_state_q)
            lowpower_pkg::RX_LPI: begin
               if (ctrl.clk_stop_en && rx_cnt_q == lowpower_pkg::LPI_HOLD_CYCLES) begin
                  rx_state_d = lowpower_pkg::RX_STOPPED;
               end
            end
            lowpower_pkg::RX_NORMAL: rx_state_d = lowpower_pkg::RX_NORMAL;
            lowpower_pkg::RX_STOPPED: rx_state_d = lowpower_pkg::RX_STOPPED;
            default: rx_state_d = lowpower_pkg::RX_NORMAL;
         endcase
      end
   end

   // Receive registers
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_state_q <= lowpower_pkg::RX_NORMAL;
         rx_div_q <= 4'h0;
         rx_phase_q <= 1'b0;
         rx_clk_q <= 1'b0;
         rx_ctl_q <= 1'b0;
         rxd_q <= 4'h0;
         rx_hi_q <= 4'h0;
         rx_er_q <= 1'b0;
         rx_cnt_q <= 4'h0;
         rx_take_q <= 1'b0;
      end else begin
         rx_state_q <= rx_state_d;
         rx_div_q <= rx_div_d;
         rx_phase_q <= rx_phase_d;
         rx_clk_q <= rx_clk_d;
         rx_ctl_q <= rx_ctl_d;
         rxd_q <= rxd_d;
         rx_hi_q <= rx_hi_d;
         rx_er_q <= rx_er_d;
         rx_cnt_q <= rx_cnt_d;
         rx_take_q <= rx_take_d;
      end
   end

   assign o_rx_clk = rx_clk_q;
   assign o_rx_ctl = rx_ctl_q;
   assign o_rxd = rxd_q;
   assign o_line_rx_take = rx_take_q;
   assign ctrl.rx_lpi = (rx_state_q != lowpower_pkg::RX_NORMAL);
   assign ctrl.rx_lpi_enter = rx_enter;

endmodule : rgmii_eee_lpi_signaling

// >>> testbench/rgmii_eee_lpi_signaling_asserts.sv
`timescale 1ns/1ps
module lpi_checker (
   // Clock, reset and speed
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_speed_1000,
   // Line receive symbol
   input wire logic i_line_rx_sleep,
   input wire logic i_line_rx_dv,
   input wire logic i_line_rx_er,
   input wire logic [7:0] i_line_rx_byte,
   // Receive pins
   input wire logic o_rx_clk,
   input wire logic o_rx_ctl,
   input wire logic [3:0] o_rxd,
   input wire logic o_line_rx_take,
   // Line transmit stream
   input wire logic o_line_tx_valid,
   input wire logic [7:0] o_line_tx_byte,
   input wire logic o_line_tx_en,
   input wire logic o_line_tx_er,
   input wire logic o_line_tx_lpi
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   // Receive side timing and data
   a_rise_with_take: assert property ($rose(o_rx_clk) |-> o_line_rx_take)
      else $error("rx clock rose without take");
   a_rx_rise_data: assert property (o_line_rx_take && !$past(i_line_rx_sleep)
      |-> o_rx_clk && o_rx_ctl == $past(i_line_rx_dv)
      && o_rxd == 4'($past(i_line_rx_byte)))
      else $error("rx rising half wrong");
   a_rx_fall_gig: assert property (o_line_rx_take && i_speed_1000
      && !$past(i_line_rx_sleep) |-> o_rx_clk[*4] ##1 (!o_rx_clk
      && o_rx_ctl == $past(i_line_rx_er, 5) && o_rxd == 4'($past(i_line_rx_byte, 5) >> 4)))
      else $error("rx falling half wrong at 1000");
   a_rx_fall_fast: assert property (o_line_rx_take && !i_speed_1000
      && !$past(i_line_rx_sleep) |-> ##10 (!o_rx_clk && o_rx_ctl == $past(i_line_rx_er, 11)
      && o_rxd == 4'($past(i_line_rx_byte, 11))))
      else $error("rx falling half wrong at 100");

   // Transmit side stream
   a_tx_lpi_entry: assert property ($rose(o_line_tx_lpi) |-> o_line_tx_valid)
      else $error("tx low power entered off a pulse");
   a_tx_lpi_code: assert property (o_line_tx_valid && o_line_tx_lpi
      |-> !o_line_tx_en && o_line_tx_er && o_line_tx_byte == lowpower_pkg::LPI_BYTE)
      else $error("tx low power without its code");
   a_tx_byte_hold: assert property (!o_line_tx_valid |-> $stable(o_line_tx_byte))
      else $error("tx byte moved between pulses");
   a_tx_fast_nibble: assert property (o_line_tx_valid && !i_speed_1000
      |-> o_line_tx_byte[7:4] == 4'h0)
      else $error("tx high nibble used at 100");

   // Main scenarios
   c_rx_stopped: cover property (o_line_rx_take && !o_rx_clk);
   c_tx_lpi: cover property ($rose(o_line_tx_lpi));
   c_rx_fast: cover property (o_line_rx_take && !i_speed_1000);
endmodule : lpi_checker

bind rgmii_eee_lpi_signaling lpi_checker i_lpi_checker (.*);

// >>> testbench/rgmii_mac_model.sv
`timescale 1ns/1ps
module rgmii_mac_model (
   // Request from the bench: {en, er, byte}
   input wire logic i_run,
   input wire logic [9:0] i_req,
   // RGMII transmit pins
   output logic o_gtx_clk,
   output logic o_tx_ctl,
   output logic [3:0] o_txd
);
   logic [9:0] cur, prv;
   int lpi_cnt;

   // 200 ns period, data set 50 ns ahead of each edge
   initial begin
      o_gtx_clk = 1'b0;
      o_tx_ctl = 1'b0;
      o_txd = 4'h0;
      cur = 10'h000;
      prv = 10'h000;
      lpi_cnt = 0;
      forever begin
         if (!i_run && lpi_cnt >= 10) begin
            wait (i_run);
            #5; // Restart off the system clock edge
         end
         cur = i_req;
         lpi_cnt = (cur == 10'h101) ? lpi_cnt + 1 : 0;
         o_tx_ctl = cur[9];
         o_txd = cur[3:0];
         #50 o_gtx_clk = 1'b1;
         #50 o_tx_ctl = cur[8];
         o_txd = cur[7:4];
         #50 o_gtx_clk = 1'b0;
         prv = cur;
         #50;
      end
   end
endmodule : rgmii_mac_model

// >>> testbench/rgmii_eee_lpi_signaling_test.sv
`timescale 1ns/1ps
module rgmii_eee_lpi_signaling_test;
   logic i_clk_sys, i_gtx_clk, i_tx_ctl, o_rx_clk, o_rx_ctl, o_line_rx_take;
   logic o_line_tx_valid, o_line_tx_en, o_line_tx_er, o_line_tx_lpi;
   logic i_line_rx_dv, i_line_rx_er, i_line_rx_sleep;
   logic i_reset_n = 1'b0;
   logic i_speed_1000 = 1'b1;
   logic i_mgmt_wr = 1'b0;
   logic i_mgmt_rd = 1'b0;
   logic [3:0] i_txd, o_rxd;
   logic [7:0] o_line_tx_byte, i_line_rx_byte;
   logic [4:0] i_mgmt_mmd = 5'h00;
   logic [15:0] i_mgmt_reg = 16'h0000;
   logic [15:0] i_mgmt_wdata = 16'h0000;
   logic [15:0] i_partner_adv = 16'h0000;
   logic [15:0] o_mgmt_rdata, lfsr, r_rx, r_tx, r_main;
   logic [10:0] rx_sym = 11'h000;
   logic [10:0] taken;
   logic [9:0] tx_req = 10'h000;
   logic mac_run = 1'b1;
   logic lpi_en = 1'b0;
   logic need_new = 1'b0;
   int n_fail, checks, cyc, ph, run_n, n_tx, tx_mode, rx_sleep_n;

   assign {i_line_rx_sleep, i_line_rx_dv, i_line_rx_er, i_line_rx_byte} = rx_sym;

   rgmii_eee_lpi_signaling i_dut (.*);
   rgmii_mac_model i_mac (.i_run(mac_run), .i_req(tx_req), .o_gtx_clk(i_gtx_clk),
      .o_tx_ctl(i_tx_ctl), .o_txd(i_txd));

   // System clock
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd

   // Expected stream word: {lpi, en, er, byte}
   function automatic logic [15:0] tx_exp(input logic [9:0] c);
      logic [9:0] x;
      x = i_speed_1000 ? c : {c[9:8], 4'h0, c[3:0]};
      return {5'h00, lpi_en && x == 10'h101, x};
   endfunction : tx_exp

   // Expected pins: {clk, ctl, rxd}; low power looks like en 0, er 1, byte 01
   function automatic logic [15:0] rx_exp(input logic fall, input logic [10:0] s);
      logic [9:0] t;
      t = (s[10] && lpi_en) ? 10'h101 : s[9:0];
      if (fall) return {11'h000, t[8], i_speed_1000 ? t[7:4] : t[3:0]};
      return {10'h000, 1'b1, t[9], t[3:0]};
   endfunction : rx_exp

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic mgmt(input logic wr, input logic [4:0] mmd, input logic [15:0] rg,
         input logic [15:0] d);
      @(posedge i_clk_sys);
      i_mgmt_wr <= wr;
      i_mgmt_rd <= !wr;
      i_mgmt_mmd <= mmd;
      i_mgmt_reg <= rg;
      i_mgmt_wdata <= d;
      @(posedge i_clk_sys);
      i_mgmt_wr <= 1'b0;
      i_mgmt_rd <= 1'b0;
      repeat (2) @(negedge i_clk_sys);
   endtask : mgmt

   task automatic rd(input logic [4:0] mmd, input logic [15:0] rg, input logic [15:0] exp);
      mgmt(1'b0, mmd, rg, 16'h0000);
      check(o_mgmt_rdata, exp);
   endtask : rd

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   // Monitors: receive halves against the taken symbol, transmit pulses
   always @(negedge i_clk_sys) begin
      if (!i_reset_n) begin
         run_n = 0;
         ph = 99;
         n_tx = 0;
      end else begin
         ph++;
         if (o_line_rx_take) begin
            ph = 0;
            taken = rx_sym;
            run_n = (rx_sym[10] && lpi_en) ? run_n + 1 : 0;
            need_new = 1'b1;
            if (run_n <= 10) check({10'h000, o_rx_clk, o_rx_ctl, o_rxd}, rx_exp(1'b0, taken));
            if (run_n >= 13) check({15'h0000, o_rx_clk}, 16'h0000);
         end
         if (ph == (i_speed_1000 ? 4 : 10) && run_n < 10) check({10'h000, o_rx_clk, o_rx_ctl,
            o_rxd}, rx_exp(1'b1, taken));
         if (o_line_tx_valid) n_tx++;
         if (o_line_tx_valid && n_tx > 2) check({5'h00, o_line_tx_lpi, o_line_tx_en,
            o_line_tx_er, o_line_tx_byte}, tx_exp(i_mac.prv));
      end
   end

   // New line symbol after each take
   always @(posedge i_clk_sys) begin
      if (need_new) begin
         need_new = 1'b0;
         r_rx = rnd();
         rx_sym <= {rx_sleep_n > 0, r_rx[9:0]};
         if (rx_sleep_n > 0) rx_sleep_n--;
      end
   end

   // Transmit request once per GTX period
   always @(posedge i_gtx_clk) begin
      @(posedge i_clk_sys);
      r_tx = rnd();
      if (tx_mode == 0) tx_req <= {1'b1, r_tx[8:0]};
      else if (tx_mode == 1) tx_req <= 10'h101;
      else tx_req <= 10'h181;
   end

   // Hang guard
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         test_done();
      end
   end

   // Main sequence, once per speed
   initial begin
      lfsr = 16'h005d;
      for (int s = 1; s >= 0; s--) begin
         r_main = rnd();
         i_reset_n <= 1'b0;
         i_speed_1000 <= s[0];
         i_partner_adv <= r_main | 16'h0006;
         lpi_en = 1'b0;
         repeat (5) @(posedge i_clk_sys);
         i_reset_n <= 1'b1;
         repeat (10) @(posedge i_clk_sys);
         rd(5'h03, 16'h0000, 16'h0400);
         rd(5'h07, 16'h003c, 16'h0000);
         rd(5'h07, 16'h003d, r_main | 16'h0006);
         rd(5'h1f, 16'h0000, 16'h0000);
         mgmt(1'b1, 5'h03, 16'h0001, 16'hffff);
         rd(5'h03, 16'h0001, 16'h0000);
         // Requests ignored while not advertised
         tx_mode = 1;
         rx_sleep_n = 12;
         repeat (200) @(posedge i_clk_sys);
         tx_mode = 0;
         wait (rx_sleep_n == 0);
         repeat (50) @(posedge i_clk_sys);
         mgmt(1'b1, 5'h07, 16'h003c, 16'h0006);
         rd(5'h07, 16'h003c, 16'h0006);
         lpi_en = 1'b1;
         // Both paths asleep, then transmit clock stopped and resumed
         tx_mode = 1;
         rx_sleep_n = 60;
         repeat (240) @(posedge i_clk_sys);
         mac_run <= 1'b0;
         repeat (20) @(posedge i_clk_sys);
         check({15'h0000, o_line_tx_lpi}, 16'h0001);
         rd(5'h03, 16'h0001, 16'h1f00);
         tx_mode = 2;
         mac_run <= 1'b1;
         repeat (40) @(posedge i_clk_sys);
         tx_mode = 0;
         repeat (40) @(posedge i_clk_sys);
         rd(5'h03, 16'h0001, 16'h0100);
         wait (rx_sleep_n == 0);
         repeat (50) @(posedge i_clk_sys);
      end
      test_done();
   end
endmodule : rgmii_eee_lpi_signaling_test
